// ===== lcdsd_seg_cell.sv
// shared constants and the per-segment drive level cell
`timescale 1ns/1ps
`default_nettype none
package lcdsd_pkg;
	localparam int NUM_COM       = 4;
	localparam int NUM_SEG       = 20;
	localparam int NUM_PAIR      = 10;
	localparam int FRAME_DIV_DEF = 4096;
	localparam int DUTY3_NUM     = 3;
	localparam int DUTY3_DEN     = 4;
	localparam int MEM_AW        = 5;
	localparam int MEM_DW        = 4;
	localparam logic [15:0] MEM_BASE = 16'hF000;
	localparam logic [15:0] MEM_LAST = 16'hF013;
	localparam logic [MEM_AW-1:0] MEM_TOP_IDX = MEM_AW'(MEM_LAST - MEM_BASE);
	typedef logic [1:0] lcdsd_lvl_t;
	localparam lcdsd_lvl_t LV_GND = 2'h0;
	localparam lcdsd_lvl_t LV_LOW = 2'h1;
	localparam lcdsd_lvl_t LV_MID = 2'h2;
	localparam lcdsd_lvl_t LV_TOP = 2'h3;
	typedef enum logic [2:0] {
		DUTY_4 = 3'h1,
		DUTY_3 = 3'h2,
		DUTY_2 = 3'h4
	} lcdsd_duty_e;
endpackage : lcdsd_pkg

module lcdsd_seg_cell (
	input  wire logic [lcdsd_pkg::MEM_DW-1:0] bits_i,
	input  wire logic [1:0]                   com_idx_i,
	input  wire logic                         pol_i,
	input  wire logic                         static_i,
	input  wire logic                         force_on_i,
	input  wire logic                         force_off_i,
	input  wire logic                         power_i,
	input  wire logic                         dc_i,
	output var  lcdsd_pkg::lcdsd_lvl_t        level_o
);
	wire logic                  lit_dyn;
	wire logic                  lit_st;
	wire logic                  lit;
	wire lcdsd_pkg::lcdsd_lvl_t on_lvl;
	wire lcdsd_pkg::lcdsd_lvl_t off_lvl;
	wire lcdsd_pkg::lcdsd_lvl_t wave;

	assign lit_dyn = bits_i[com_idx_i];
	assign lit_st  = |bits_i;
	assign lit     = force_on_i ? 1'b1 : (force_off_i ? 1'b0 : (static_i ? lit_st : lit_dyn));
	assign on_lvl  = pol_i ? lcdsd_pkg::LV_GND : lcdsd_pkg::LV_TOP;
	assign off_lvl = static_i ? (pol_i ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND)
	                          : (pol_i ? lcdsd_pkg::LV_MID : lcdsd_pkg::LV_LOW);
	assign wave    = lit ? on_lvl : off_lvl;

	always_comb begin
		if (dc_i) begin
			level_o = bits_i[0] ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND;
		end else if (!power_i) begin
			level_o = lcdsd_pkg::LV_GND;
		end else begin
			level_o = wave;
		end
	end
endmodule : lcdsd_seg_cell
`default_nettype wire

// ===== lcdsd_top.sv
// segment lcd driver: display memory, frame timing, common and segment levels
//
// Overview of operation
// - four commons, twenty segments, eighty max
// - power off grounds levels and outputs
// - dc pins ignore power control
// - all-on forces on waveform on every non-dc segment pin while powered
// - all-off forces off; clearing restores memory
// - all-on wins over all-off
// - forces are plain inputs, not cleared by reset or power off
// - duty bits pick four, three, two commons
// - quarter and half duty: tick/4096 frame
// - third duty frame is 4/3 faster
// - static: any common bit lights segment
// - static: all bits zero means off
// - twenty-word memory, fixed segment mapping
// - one lights, zero leaves unlit
// - memory read/write, undefined after reset
// - dc pin outputs common zero bit
// - dc option chosen per pin pair
`default_nettype none
`timescale 1ns/1ps
module lcdsd_top #(
	parameter int                             FRAME_DIV = lcdsd_pkg::FRAME_DIV_DEF,
	parameter logic [lcdsd_pkg::NUM_PAIR-1:0] DC_PAIRS  = '0
) (
	input  wire logic                                clk_i,
	input  wire logic                                srst_i,
	input  wire logic                                prs_tick_i,
	input  wire logic                                lcd_power_on_i,
	input  wire logic                                force_all_segments_on_i,
	input  wire logic                                force_all_segments_off_i,
	input  wire logic                                static_drive_select_i,
	input  wire logic                                duty_select_high_i,
	input  wire logic                                duty_select_low_i,
	input  wire logic                                mem_we_i,
	input  wire logic [lcdsd_pkg::MEM_AW-1:0]        mem_addr_i,
	input  wire logic [lcdsd_pkg::MEM_DW-1:0]        mem_wdata_i,
	output logic      [lcdsd_pkg::MEM_DW-1:0]        mem_rdata_o,
	output logic                                     bias_enable_o,
	output logic      [lcdsd_pkg::NUM_COM-1:0][1:0]  common_outputs_o,
	output logic      [lcdsd_pkg::NUM_SEG-1:0][1:0]  segment_outputs_o
);
	localparam int CNT_W = $clog2(FRAME_DIV);
	localparam logic [CNT_W-1:0] LAST_FULL  = CNT_W'(FRAME_DIV - 1);
	localparam logic [CNT_W-1:0] LAST_THIRD =
		CNT_W'(FRAME_DIV * lcdsd_pkg::DUTY3_NUM / lcdsd_pkg::DUTY3_DEN - 1);

	logic [lcdsd_pkg::MEM_DW-1:0]  mem_r [lcdsd_pkg::NUM_SEG];
	logic [CNT_W-1:0]              cnt_r;
	logic [CNT_W-1:0]              cnt_nxt;
	logic                          pol_r;
	logic                          pol_nxt;
	logic [lcdsd_pkg::NUM_SEG-1:0] wr_seen_r;

	wire lcdsd_pkg::lcdsd_duty_e                   duty;
	wire logic [CNT_W-1:0]                         frame_last;
	wire logic                                     frame_end;
	wire logic [1:0]                               com_idx;
	wire logic                                     addr_ok;
	wire logic [lcdsd_pkg::NUM_SEG-1:0]            dc_mask;
	wire logic [lcdsd_pkg::NUM_COM-1:0][1:0]       com_nxt;
	wire logic [lcdsd_pkg::NUM_SEG-1:0][1:0]       seg_nxt;
	wire logic [lcdsd_pkg::MEM_DW-1:0]             rdata_nxt;

	assign duty = duty_select_high_i ? lcdsd_pkg::DUTY_2
	            : (duty_select_low_i ? lcdsd_pkg::DUTY_3 : lcdsd_pkg::DUTY_4);
	assign frame_last = (duty == lcdsd_pkg::DUTY_3) ? LAST_THIRD : LAST_FULL;
	assign frame_end  = cnt_r >= frame_last;
	assign com_idx = (duty == lcdsd_pkg::DUTY_2) ? {1'b0, cnt_r[CNT_W-1]} : cnt_r[CNT_W-1 -: 2];

	always_comb begin
		cnt_nxt = cnt_r;
		pol_nxt = pol_r;
		if (prs_tick_i) begin
			if (frame_end) begin
				cnt_nxt = '0;
				pol_nxt = ~pol_r;
			end else begin
				cnt_nxt = cnt_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cnt_r <= '0;
			pol_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			pol_r <= pol_nxt;
		end
	end

	assign addr_ok   = mem_addr_i <= lcdsd_pkg::MEM_TOP_IDX;
	assign rdata_nxt = addr_ok ? mem_r[mem_addr_i] : '0;

	always_ff @(posedge clk_i) begin
		if (mem_we_i && addr_ok) begin
			mem_r[mem_addr_i] <= mem_wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			wr_seen_r <= '0;
		end else if (mem_we_i && addr_ok) begin
			wr_seen_r[mem_addr_i] <= 1'b1;
		end
	end

	genvar gc;
	genvar gs;
	generate
		for (gc = 0; gc < lcdsd_pkg::NUM_COM; gc++) begin : g_com
			assign com_nxt[gc] = !lcd_power_on_i ? lcdsd_pkg::LV_GND
				: ((static_drive_select_i || com_idx == 2'(gc))
					? (pol_r ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND)
					: (pol_r ? lcdsd_pkg::LV_LOW : lcdsd_pkg::LV_MID));
		end
		for (gs = 0; gs < lcdsd_pkg::NUM_SEG; gs++) begin : g_seg
			assign dc_mask[gs] = DC_PAIRS[gs / 2];
			lcdsd_seg_cell u_cell (
				.bits_i      (mem_r[gs]),
				.com_idx_i   (com_idx),
				.pol_i       (pol_r),
				.static_i    (static_drive_select_i),
				.force_on_i  (force_all_segments_on_i),
				.force_off_i (force_all_segments_off_i),
				.power_i     (lcd_power_on_i),
				.dc_i        (dc_mask[gs]),
				.level_o     (seg_nxt[gs])
			);

			dc_follow_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(dc_mask[gs] && wr_seen_r[gs]) |=> segment_outputs_o[gs] ==
					($past(mem_r[gs][0]) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
				else $error("dc pin does not follow bit0");

			force_on_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(lcd_power_on_i && force_all_segments_on_i && !dc_mask[gs])
				|=> segment_outputs_o[gs] ==
					($past(pol_r) ? lcdsd_pkg::LV_GND : lcdsd_pkg::LV_TOP))
				else $error("all-on waveform missing");

			force_off_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(lcd_power_on_i && force_all_segments_off_i && !force_all_segments_on_i
					&& !static_drive_select_i && !dc_mask[gs])
				|=> segment_outputs_o[gs] ==
					($past(pol_r) ? lcdsd_pkg::LV_MID : lcdsd_pkg::LV_LOW))
				else $error("all-off waveform missing");

			static_off_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(lcd_power_on_i && static_drive_select_i && !force_all_segments_on_i
					&& mem_r[gs] == '0 && !dc_mask[gs])
				|=> segment_outputs_o[gs] ==
					($past(pol_r) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
				else $error("static off level wrong");

			seg_unpowered_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(!lcd_power_on_i && !dc_mask[gs]) |=> segment_outputs_o[gs] == lcdsd_pkg::LV_GND)
				else $error("segment not grounded with power off");

			dyn_level_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(lcd_power_on_i && !static_drive_select_i && !force_all_segments_on_i
					&& !force_all_segments_off_i && !dc_mask[gs] && wr_seen_r[gs])
				|=> segment_outputs_o[gs] == ($past(mem_r[gs][com_idx])
					? ($past(pol_r) ? lcdsd_pkg::LV_GND : lcdsd_pkg::LV_TOP)
					: ($past(pol_r) ? lcdsd_pkg::LV_MID : lcdsd_pkg::LV_LOW)))
				else $error("dynamic segment level wrong");

			static_on_a: assert property (
				@(posedge clk_i) disable iff (srst_i)
				(lcd_power_on_i && static_drive_select_i && !force_all_segments_off_i
					&& !dc_mask[gs] && wr_seen_r[gs] && mem_r[gs] != '0)
				|=> segment_outputs_o[gs] ==
					($past(pol_r) ? lcdsd_pkg::LV_GND : lcdsd_pkg::LV_TOP))
				else $error("static on level wrong");
		end
	endgenerate

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			mem_rdata_o       <= '0;
			bias_enable_o     <= 1'b0;
			common_outputs_o  <= '0;
			segment_outputs_o <= '0;
		end else begin
			mem_rdata_o       <= rdata_nxt;
			bias_enable_o     <= lcd_power_on_i;
			common_outputs_o  <= com_nxt;
			segment_outputs_o <= seg_nxt;
		end
	end

	power_off_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!lcd_power_on_i |=> (common_outputs_o == '0 && !bias_enable_o))
		else $error("commons not grounded with power off");

	frame_wrap_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(prs_tick_i && cnt_r == frame_last) |=> (cnt_r == '0 && pol_r != $past(pol_r)))
		else $error("frame did not wrap");

	third_len_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(duty == lcdsd_pkg::DUTY_3 && cnt_r <= LAST_THIRD) |=> cnt_r <= LAST_THIRD)
		else $error("third-duty frame overran");

	half_idle_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && !static_drive_select_i && duty == lcdsd_pkg::DUTY_2)
		|=> common_outputs_o[2] == ($past(pol_r) ? lcdsd_pkg::LV_LOW : lcdsd_pkg::LV_MID))
		else $error("unused common selected in half duty");

	com_active_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && com_idx == 2'h0)
		|=> common_outputs_o[0] == ($past(pol_r) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
		else $error("active common level wrong");

	mem_rw_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(mem_we_i && addr_ok) ##1 (!mem_we_i && mem_addr_i == $past(mem_addr_i))
		|=> mem_rdata_o == $past(mem_wdata_i, 2))
		else $error("memory readback mismatch");

	reset_clear_a: assert property (
		@(posedge clk_i)
		srst_i |=> (common_outputs_o == '0 && segment_outputs_o == '0 && !bias_enable_o
			&& cnt_r == '0 && !pol_r))
		else $error("outputs not cleared by reset");

	bias_on_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		lcd_power_on_i |=> bias_enable_o)
		else $error("bias not enabled with power on");

	tick_hold_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!prs_tick_i |=> ($stable(cnt_r) && $stable(pol_r)))
		else $error("frame counter moved without tick");

	full_count_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(prs_tick_i && duty != lcdsd_pkg::DUTY_3 && cnt_r != LAST_FULL)
		|=> cnt_r == $past(cnt_r) + 1'b1)
		else $error("full frame ended early");

	pol_hold_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!(prs_tick_i && frame_end) |=> $stable(pol_r))
		else $error("polarity flipped inside frame");

	third_idle_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && !static_drive_select_i && duty == lcdsd_pkg::DUTY_3)
		|=> common_outputs_o[3] == ($past(pol_r) ? lcdsd_pkg::LV_LOW : lcdsd_pkg::LV_MID))
		else $error("unused common selected in third duty");

	half_idle3_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && !static_drive_select_i && duty == lcdsd_pkg::DUTY_2)
		|=> common_outputs_o[3] == ($past(pol_r) ? lcdsd_pkg::LV_LOW : lcdsd_pkg::LV_MID))
		else $error("last common selected in half duty");

	static_com_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && static_drive_select_i)
		|=> common_outputs_o[3] == ($past(pol_r) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
		else $error("static common level wrong");

	mem_range_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		!addr_ok |=> mem_rdata_o == '0)
		else $error("read beyond memory not zero");

	half_slice_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && !static_drive_select_i && duty == lcdsd_pkg::DUTY_2 && cnt_r[CNT_W-1])
		|=> common_outputs_o[1] == ($past(pol_r) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
		else $error("second common not active in half duty");

	quarter_last_a: assert property (
		@(posedge clk_i) disable iff (srst_i)
		(lcd_power_on_i && !static_drive_select_i && duty == lcdsd_pkg::DUTY_4
			&& cnt_r[CNT_W-1 -: 2] == 2'h3)
		|=> common_outputs_o[3] == ($past(pol_r) ? lcdsd_pkg::LV_TOP : lcdsd_pkg::LV_GND))
		else $error("last common not active in quarter duty");
endmodule : lcdsd_top
`default_nettype wire

// ===== lcdsd_panel.sv
// lcd glass model: a cell is lit while full bias stands across it
`timescale 1ns/1ps
`default_nettype none
module lcdsd_panel (
	input  wire logic [3:0][1:0]  com_i,
	input  wire logic [19:0][1:0] seg_i,
	output logic      [19:0][3:0] lit_o
);
	always_comb begin
		for (int s = 0; s < 20; s++) begin
			for (int c = 0; c < 4; c++) begin
				lit_o[s][c] = (com_i[c] == 2'h3 && seg_i[s] == 2'h0)
					|| (com_i[c] == 2'h0 && seg_i[s] == 2'h3);
			end
		end
	end
endmodule : lcdsd_panel
`default_nettype wire

// ===== lcd_segment_driver_tb.sv
// self-checking bench for the segment lcd driver
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_driver_tb;
	localparam int FD = 16;
	logic clk_i = 0, srst_i = 1, pwr = 0, fon = 0, foff = 0, stat = 0, dh = 0, dl = 0, we = 0;
	logic tick = 1, half = 0;
	logic [4:0] addr = '0;
	logic [3:0] wd = '0, rd;
	logic bias;
	logic [3:0][1:0] com;
	logic [19:0][1:0] seg;
	logic [19:0][3:0] lit, seen, mem;
	int sel [4];
	int failures = 0, checks = 0;
	lcdsd_top #(.FRAME_DIV(FD), .DC_PAIRS(10'h200)) dut (.clk_i(clk_i), .srst_i(srst_i),
		.prs_tick_i(tick), .lcd_power_on_i(pwr), .force_all_segments_on_i(fon),
		.force_all_segments_off_i(foff), .static_drive_select_i(stat),
		.duty_select_high_i(dh), .duty_select_low_i(dl), .mem_we_i(we), .mem_addr_i(addr),
		.mem_wdata_i(wd), .mem_rdata_o(rd), .bias_enable_o(bias),
		.common_outputs_o(com), .segment_outputs_o(seg));
	lcdsd_panel glass (.com_i(com), .seg_i(seg), .lit_o(lit));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		tick <= half ? ~tick : 1'b1;
	end
	function automatic logic [1:0] dc(input int s);
		return mem[s][0] ? 2'h3 : 2'h0;
	endfunction : dc
	task automatic chk(input string what, input logic [63:0] s, input logic [63:0] e);
		checks++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH %s expected %0h seen %0h", what, e, s);
		end
	endtask : chk
	task automatic wr(input int a, input logic [3:0] d);
		@(negedge clk_i);
		we = 1;
		addr = 5'(a);
		wd = d;
		@(negedge clk_i);
		we = 0;
	endtask : wr
	task automatic rdc(input int a, input logic [3:0] e);
		@(negedge clk_i);
		addr = 5'(a);
		repeat (2) @(negedge clk_i);
		chk("rdata", 64'(rd), 64'(e));
	endtask : rdc
	task automatic scan(input int n);
		seen = '0;
		sel = '{0, 0, 0, 0};
		repeat (2 * FD) @(negedge clk_i);
		repeat (n) begin
			@(negedge clk_i);
			seen |= lit;
			for (int c = 0; c < 4; c++) begin
				sel[c] += int'(com[c] == 2'h3 || com[c] == 2'h0);
			end
		end
	endtask : scan
	task automatic cmp(input logic [3:0] used, input int mode);
		logic [3:0] e;
		for (int s = 0; s < 18; s++) begin
			case (mode)
				0: e = mem[s] & used;
				1: e = used;
				2: e = 4'h0;
				default: e = (|mem[s]) ? 4'hF : 4'h0;
			endcase
			chk("lit", 64'(seen[s]), 64'(e));
		end
	endtask : cmp
	task automatic end_sim;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		repeat (4) @(negedge clk_i);
		srst_i = 0;
		chk("com", 64'(com), 64'h0);
		chk("bias", 64'(bias), 64'h0);
		for (int s = 0; s < 20; s++) begin
			mem[s] = 4'(s * 7 + 3);
			wr(s, mem[s]);
		end
		rdc(5, mem[5]);
		rdc(19, mem[19]);
		rdc(20, 4'h0);
		chk("seg", 64'(seg), 64'({dc(19), dc(18), 36'h0}));
		pwr = 1;
		for (int d = 0; d < 3; d++) begin
			{dh, dl} = 2'(d + d / 2);
			scan(d == 1 ? FD * 3 / 2 : 2 * FD);
			cmp(4'hF >> d, 0);
			for (int c = 0; c < 4; c++) begin
				chk("slots", 64'(sel[c]), c > 3 - d ? 0 : (d == 2 ? FD : FD / 2));
			end
		end
		chk("bias", 64'(bias), 64'h1);
		{dh, dl} = 2'h0;
		stat = 1;
		scan(2 * FD);
		cmp(4'hF, 3);
		stat = 0;
		fon = 1;
		scan(2 * FD);
		cmp(4'hF, 1);
		foff = 1;
		scan(2 * FD);
		cmp(4'hF, 1);
		fon = 0;
		scan(2 * FD);
		cmp(4'hF, 2);
		chk("dc", 64'(seg[18]), 64'(dc(18)));
		foff = 0;
		scan(2 * FD);
		cmp(4'hF, 0);
		half = 1;
		scan(4 * FD);
		cmp(4'hF, 0);
		chk("slots", 64'(sel[0]), 64'(FD));
		half = 0;
		pwr = 0;
		repeat (2) @(negedge clk_i);
		chk("seg", 64'(seg), 64'({dc(19), dc(18), 36'h0}));
		chk("com", 64'(com), 64'h0);
		end_sim();
	end
endmodule : lcd_segment_driver_tb
`default_nettype wire
